// File: design/jbab_access.sv
// debug-link register access block with system bus master
`timescale 1ns/1ps
`default_nettype none
`include "jbab_regs.svh"
module jbab_access #(parameter int DEPTH = `JBAB_BURST_WORDS) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tck, // debug link clock pin
	input wire logic tms, // link mode select pin
	input wire logic tdi, // link serial data in
	output logic tdo, // link serial data out
	output logic tdoOe, // high while tdo is driven
	output logic xferDone, // completion pin
	output logic busReq, // bus request, held until ack
	output logic busWrite, // bus direction
	output logic [31:0] busAddr, // bus byte address
	output logic [31:0] busWdata, // bus write word
	output logic [1:0] busSize, // 0 byte, 1 half, 2 word
	output logic [1:0] busPrio, // arbitration level
	input wire logic busAck, // one-cycle completion of a beat
	input wire logic busErr, // beat failed, with ack
	input wire logic [31:0] busRdata // read word, with ack
);
	localparam int AW = 3; // buffer index width
	initial
	begin
		if (DEPTH != `JBAB_BURST_WORDS)
			$error("burst buffer must hold exactly one burst");
	end

	// synchronised pins and link clock edges
	logic [2:0] pinSync; // {tdi, tms, tck} after two stages
	logic tckLast; // previous synchronised link clock
	logic tckRise; // link clock rising edge seen
	logic tckFall; // link clock falling edge seen
	jbab_pin_sync #(.WIDTH(3)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pinIn({tdi, tms, tck}),
		.pinSync(pinSync)
	);
	assign tckRise = pinSync[0] & ~tckLast;
	assign tckFall = ~pinSync[0] & tckLast;
	// delayed link clock for edge finding
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tckLast <= 1'b0;
		else
			tckLast <= pinSync[0];
	end

	// burst buffer
	jbab_buf_if #(.AW(AW)) bufBus ();
	jbab_burst_buf #(.DEPTH(DEPTH), .AW(AW)) u_buf (
		.mclk(mclk),
		.bus(bufBus)
	);

	// link-side state
	jbab_pkg::jbab_tap_t tapState; // port controller state
	jbab_pkg::jbab_tap_t next_tapState; // its successor
	logic [9:0] irShift; // command shift path
	logic [9:0] cmdReg; // emulation command register
	logic [31:0] shiftReg; // data shift path
	logic dataPhase; // 0 select pass next, 1 data pass next
	logic [6:0] selIdx; // selected register index
	logic selWrite; // selected direction, 1 write
	logic accessOn; // bus-access command is loaded
	// register file
	logic [31:0] ctrlReg; // control/status register
	logic [31:0] addrReg; // address register
	logic [31:0] dataReg; // data register
	logic [AW-1:0] wrPtr; // burst write fill index
	logic [AW-1:0] rdPtr; // burst read drain index
	logic goBus; // one-cycle launch of a bus sequence
	// bus-side state
	jbab_pkg::jbab_bus_t busState; // sequencer state
	logic [AW-1:0] beat; // current burst beat
	logic busy; // sequence in progress
	logic lastBeat; // this beat ends the sequence
	logic burstMode; // running sequence is a burst
	logic [1:0] effSize; // bus size of the running sequence
	logic updDr; // update pass into data register path
	logic capDr; // capture in data register path

	assign accessOn = (cmdReg == `JBAB_CMD_BUS_ACCESS);
	assign updDr = tckRise && tapState == jbab_pkg::UPD_DR && accessOn;
	assign capDr = tckRise && tapState == jbab_pkg::CAP_DR && accessOn;
	assign burstMode = ctrlReg[`JBAB_BIT_BURST];
	assign busy = (busState != jbab_pkg::BIDLE);
	assign lastBeat = !burstMode || beat == AW'(DEPTH - 1);
	// reserved widths default to word; bursts move words
	assign effSize = (burstMode ||
		ctrlReg[`JBAB_WIDTH_HI:`JBAB_WIDTH_LO] > 3'h2) ? 2'h2 :
		ctrlReg[`JBAB_WIDTH_LO+1:`JBAB_WIDTH_LO];

	// port controller next state, driven by sampled mode select
	always_comb
	begin
		case (tapState)
			jbab_pkg::TLR: next_tapState = pinSync[1] ? jbab_pkg::TLR :
				jbab_pkg::RTI;
			jbab_pkg::RTI, jbab_pkg::UPD_DR, jbab_pkg::UPD_IR:
				next_tapState = pinSync[1] ? jbab_pkg::SEL_DR : jbab_pkg::RTI;
			jbab_pkg::SEL_DR: next_tapState = pinSync[1] ? jbab_pkg::SEL_IR :
				jbab_pkg::CAP_DR;
			jbab_pkg::CAP_DR, jbab_pkg::SHF_DR, jbab_pkg::EX2_DR:
				next_tapState = pinSync[1] ? jbab_pkg::EX1_DR :
				jbab_pkg::SHF_DR;
			jbab_pkg::EX1_DR: next_tapState = pinSync[1] ? jbab_pkg::UPD_DR :
				jbab_pkg::PAU_DR;
			jbab_pkg::PAU_DR: next_tapState = pinSync[1] ? jbab_pkg::EX2_DR :
				jbab_pkg::PAU_DR;
			jbab_pkg::SEL_IR: next_tapState = pinSync[1] ? jbab_pkg::TLR :
				jbab_pkg::CAP_IR;
			jbab_pkg::CAP_IR, jbab_pkg::SHF_IR, jbab_pkg::EX2_IR:
				next_tapState = pinSync[1] ? jbab_pkg::EX1_IR :
				jbab_pkg::SHF_IR;
			jbab_pkg::EX1_IR: next_tapState = pinSync[1] ? jbab_pkg::UPD_IR :
				jbab_pkg::PAU_IR;
			jbab_pkg::PAU_IR: next_tapState = pinSync[1] ? jbab_pkg::EX2_IR :
				jbab_pkg::PAU_IR;
			default: next_tapState = jbab_pkg::TLR;
		endcase
	end

	// port controller advances on each link clock rise
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tapState <= jbab_pkg::TLR;
		else if (tckRise)
			tapState <= next_tapState;
	end

	// command path: loading the bus-access command opens the block
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irShift <= `JBAB_IR_CAPTURE;
			cmdReg <= `JBAB_IR_RESET;
		end
		else if (tckRise)
		begin
			case (tapState)
				jbab_pkg::TLR: cmdReg <= `JBAB_IR_RESET;
				jbab_pkg::CAP_IR: irShift <= `JBAB_IR_CAPTURE;
				jbab_pkg::SHF_IR: irShift <= {pinSync[2], irShift[9:1]};
				jbab_pkg::UPD_IR: cmdReg <= irShift;
				default: irShift <= irShift;
			endcase
		end
	end

	// pass tracking: select pass, then data pass
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dataPhase <= 1'b0;
			selIdx <= 7'h00;
			selWrite <= 1'b0;
		end
		else if (tckRise && (tapState == jbab_pkg::TLR ||
			tapState == jbab_pkg::UPD_IR))
			dataPhase <= 1'b0;
		else if (updDr)
		begin
			dataPhase <= ~dataPhase;
			if (!dataPhase)
			begin
				selIdx <= shiftReg[31:25];
				selWrite <= shiftReg[24];
			end
		end
	end

	// data shift path: capture selected register, shift LSB first
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			shiftReg <= 32'h00000000;
		else if (tckRise && tapState == jbab_pkg::CAP_DR)
		begin
			if (!accessOn || !dataPhase)
				shiftReg <= 32'h00000000;
			else
			begin
				case (selIdx)
					`JBAB_IDX_CTRL: shiftReg <= ctrlReg;
					`JBAB_IDX_ADDR: shiftReg <= addrReg;
					`JBAB_IDX_DATA: shiftReg <= (burstMode &&
						!ctrlReg[`JBAB_BIT_DIR]) ? bufBus.rdData : dataReg;
					default: shiftReg <= 32'h00000000;
				endcase
			end
		end
		else if (tckRise && tapState == jbab_pkg::SHF_DR)
			shiftReg <= {pinSync[2], shiftReg[31:1]};
	end

	// serial output changes on the link clock fall
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tdo <= 1'b0;
			tdoOe <= 1'b0;
		end
		else if (tckFall)
		begin
			tdoOe <= (tapState == jbab_pkg::SHF_DR ||
				tapState == jbab_pkg::SHF_IR);
			// a select pass is 8 bits long, so its bits sit high
			tdo <= (tapState == jbab_pkg::SHF_IR) ? irShift[0] :
				(dataPhase ? shiftReg[0] : shiftReg[24]);
		end
	end

	// register file: link updates and bus results
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrlReg <= `JBAB_CTRL_RST;
			addrReg <= `JBAB_ADDR_RST;
			dataReg <= `JBAB_DATA_RST;
			wrPtr <= '0;
			rdPtr <= '0;
			goBus <= 1'b0;
		end
		else
		begin
			goBus <= 1'b0;
			if (busy && busState == jbab_pkg::BWAIT && busAck &&
				(busErr || lastBeat))
			begin
				ctrlReg[`JBAB_BIT_START] <= 1'b0;
				ctrlReg[`JBAB_BIT_FAULT] <= busErr;
				ctrlReg[`JBAB_BIT_VALID] <= !busErr &&
					!ctrlReg[`JBAB_BIT_DIR];
				if (!busErr && !burstMode && !ctrlReg[`JBAB_BIT_DIR])
					dataReg <= jbab_pkg::jbab_swap(busRdata, effSize);
			end
			else if (updDr && dataPhase && selWrite)
			begin
				case (selIdx)
					`JBAB_IDX_CTRL:
					begin
						// status flags are read only
						ctrlReg[31:21] <= shiftReg[31:21];
						ctrlReg[`JBAB_COUNT_HI:`JBAB_COUNT_LO] <=
							shiftReg[`JBAB_COUNT_HI:`JBAB_COUNT_LO];
						wrPtr <= '0;
						rdPtr <= '0;
						if (shiftReg[`JBAB_BIT_START])
						begin
							// write pending shows 0/1, read pending 0/0
							ctrlReg[`JBAB_BIT_FAULT] <= 1'b0;
							ctrlReg[`JBAB_BIT_VALID] <= shiftReg[`JBAB_BIT_DIR];
							goBus <= !shiftReg[`JBAB_BIT_DIR];
						end
					end
					`JBAB_IDX_ADDR: addrReg <= shiftReg;
					`JBAB_IDX_DATA:
					begin
						dataReg <= shiftReg;
						if (burstMode)
							wrPtr <= wrPtr + AW'(1);
						// a write waits for its data, all of it in a burst
						goBus <= ctrlReg[`JBAB_BIT_START] &&
							ctrlReg[`JBAB_BIT_DIR] && !busy &&
							(!burstMode || wrPtr == AW'(DEPTH - 1));
					end
					default: ctrlReg <= ctrlReg;
				endcase
			end
			else if (capDr && dataPhase && selIdx == `JBAB_IDX_DATA &&
				burstMode && !ctrlReg[`JBAB_BIT_DIR])
				rdPtr <= rdPtr + AW'(1);
		end
	end

	// buffer ports: filled from link or bus, read by bus or link
	always_comb
	begin
		bufBus.wrEn = 1'b0;
		bufBus.wrAddr = wrPtr;
		bufBus.wrData = shiftReg;
		if (busState == jbab_pkg::BWAIT && busAck && !busWrite && burstMode)
		begin
			bufBus.wrEn = 1'b1;
			bufBus.wrAddr = beat;
			bufBus.wrData = jbab_pkg::jbab_swap(busRdata, 2'h2);
		end
		else if (updDr && dataPhase && selWrite &&
			selIdx == `JBAB_IDX_DATA && burstMode)
			bufBus.wrEn = 1'b1;
		bufBus.rdAddr = busy ? beat : rdPtr;
	end

	// bus sequencer: arbitrate, move one word per beat
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busState <= jbab_pkg::BIDLE;
			beat <= '0;
			busReq <= 1'b0;
			busWrite <= 1'b0;
			busAddr <= 32'h00000000;
			busWdata <= 32'h00000000;
			busSize <= 2'h0;
			busPrio <= 2'h0;
		end
		else
		begin
			case (busState)
				jbab_pkg::BIDLE:
				begin
					beat <= '0;
					if (goBus)
					begin
						busWrite <= ctrlReg[`JBAB_BIT_DIR];
						busSize <= effSize;
						// reserved levels fall back to lowest
						busPrio <= (ctrlReg[`JBAB_PRIO_HI:`JBAB_PRIO_LO] == 2'h3) ?
							2'h3 : 2'h0;
						busAddr <= burstMode ? {addrReg[31:3], 3'h0} :
							addrReg;
						busState <= jbab_pkg::BFETCH;
					end
				end
				jbab_pkg::BFETCH: busState <= jbab_pkg::BISSUE;
				jbab_pkg::BISSUE:
				begin
					// buffer read data is valid here
					busWdata <= burstMode ?
						jbab_pkg::jbab_swap(bufBus.rdData, 2'h2) :
						jbab_pkg::jbab_swap(dataReg, effSize);
					busReq <= 1'b1;
					busState <= jbab_pkg::BWAIT;
				end
				jbab_pkg::BWAIT:
				begin
					if (busAck)
					begin
						busReq <= 1'b0;
						if (busErr || lastBeat)
							busState <= jbab_pkg::BIDLE;
						else
						begin
							beat <= beat + AW'(1);
							busAddr <= busAddr + 32'h00000004;
							busState <= jbab_pkg::BFETCH;
						end
					end
				end
				default: busState <= jbab_pkg::BIDLE;
			endcase
		end
	end

	// completion pin: high after a clean finish until next launch
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			xferDone <= 1'b0;
		else if (busState == jbab_pkg::BWAIT && busAck &&
			(busErr || lastBeat))
			xferDone <= !busErr;
		else if (goBus)
			xferDone <= 1'b0;
	end

	// checks
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_flags_exclusive: assert property (
		!(ctrlReg[`JBAB_BIT_FAULT] && ctrlReg[`JBAB_BIT_VALID]))
		else $error("fault and valid both set");
	a_write_ok_flags: assert property (
		$fell(busy) && busWrite && !ctrlReg[`JBAB_BIT_FAULT] |->
		!ctrlReg[`JBAB_BIT_VALID])
		else $error("clean write left valid set");
	a_read_ok_flags: assert property (
		$fell(busy) && !busWrite && !ctrlReg[`JBAB_BIT_FAULT] |->
		ctrlReg[`JBAB_BIT_VALID])
		else $error("clean read did not set valid");
	a_done_pin: assert property (
		$fell(busy) |-> xferDone == !ctrlReg[`JBAB_BIT_FAULT])
		else $error("completion pin wrong at finish");
	a_burst_align: assert property (
		$rose(busReq) && burstMode && beat == '0 |-> busAddr[2:0] == 3'h0)
		else $error("burst start not aligned");
	a_req_held: assert property (
		busReq && !busAck |=> busReq && $stable(busAddr))
		else $error("bus request dropped early");
	a_capture_addr: assert property (
		capDr && dataPhase && selIdx == `JBAB_IDX_ADDR |=>
		shiftReg == $past(addrReg))
		else $error("capture did not load address");
	a_update_only: assert property (
		!$stable(addrReg) |-> $past(updDr && dataPhase && selWrite))
		else $error("address changed outside update");
	a_cmd_gates: assert property (
		!accessOn |=> $stable(addrReg) && $stable(dataReg) ||
		$past(busy))
		else $error("register written without command");
	c_single_write: cover property ($fell(busy) && busWrite && !burstMode);
	c_burst_write: cover property ($fell(busy) && busWrite && burstMode);
	c_burst_read: cover property ($fell(busy) && !busWrite && burstMode);
	c_bus_error: cover property ($fell(busy) && ctrlReg[`JBAB_BIT_FAULT]);
endmodule : jbab_access
`default_nettype wire

// File: design/jbab_regs.svh
// register map, field positions, codes and reset values of the access block
// Behaviour
// - access opens only after bus-access command loaded
// - each access is select pass then data pass
// - select pass: 8 bits, index plus direction
// - data pass shifts register contents LSB first
// - read loads register at capture, shifts out
// - write lands in register only at update
// - index 9 address, 7 control, A data
// - single data right-justified little endian
// - single write arbitrates, writes data to address
// - good write ends with fault 0, valid 0
// - good read stores data, fault 0, valid 1
// - completion pin asserted on error-free finish
// - burst address 8-byte aligned, low bits ignored
// - burst write buffers 32 bytes, then memory
// - burst read fills buffer, tool reads words
// - control field layout from bit 31 down
// - failure shows fault 1 valid 0, never both
`ifndef JBAB_REGS_SVH
`define JBAB_REGS_SVH
`define JBAB_CMD_BUS_ACCESS 10'h07C
`define JBAB_IR_RESET 10'h3FF
`define JBAB_IR_CAPTURE 10'h001
`define JBAB_IDX_CTRL 7'h07
`define JBAB_IDX_ADDR 7'h09
`define JBAB_IDX_DATA 7'h0A
`define JBAB_BIT_START 31
`define JBAB_BIT_DIR 30
`define JBAB_WIDTH_HI 29
`define JBAB_WIDTH_LO 27
`define JBAB_SPACE_HI 26
`define JBAB_SPACE_LO 24
`define JBAB_PRIO_HI 23
`define JBAB_PRIO_LO 22
`define JBAB_BIT_BURST 21
`define JBAB_COUNT_HI 15
`define JBAB_COUNT_LO 2
`define JBAB_BIT_FAULT 1
`define JBAB_BIT_VALID 0
`define JBAB_CTRL_RST 32'h00000000
`define JBAB_ADDR_RST 32'h00000000
`define JBAB_DATA_RST 32'h00000000
`define JBAB_WIDTH_64 3'h3
`define JBAB_BURST_WORDS 8
`endif

// File: design/jbab_pkg.sv
// types and the byte-order helper of the access block
`default_nettype none
package jbab_pkg;
	// test access port controller states
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jbab_tap_t;
	// system bus sequencer states
	typedef enum logic [1:0] {BIDLE, BFETCH, BISSUE, BWAIT} jbab_bus_t;
	// little-endian right-justified view of bus data, its own inverse at word size
	function automatic logic [31:0] jbab_swap(input logic [31:0] d,
		input logic [1:0] sz);
		case (sz)
			2'h0: jbab_swap = {24'h000000, d[7:0]};
			2'h1: jbab_swap = {16'h0000, d[7:0], d[15:8]};
			default: jbab_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
		endcase
	endfunction : jbab_swap
endpackage : jbab_pkg
`default_nettype wire

// File: design/jbab_buf_if.sv
// port bundle between the access block and its burst buffer
`timescale 1ns/1ps
`default_nettype none
interface jbab_buf_if #(parameter int AW = 3);
	logic wrEn; // write strobe
	logic [AW-1:0] wrAddr; // write word index
	logic [31:0] wrData; // write word
	logic [AW-1:0] rdAddr; // read word index
	logic [31:0] rdData; // registered read word
	modport user (output wrEn, wrAddr, wrData, rdAddr, input rdData);
	modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface : jbab_buf_if
`default_nettype wire

// File: design/jbab_burst_buf.sv
// burst data buffer: small word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module jbab_burst_buf #(parameter int DEPTH = 8, parameter int AW = 3) (
	input wire logic mclk,
	jbab_buf_if.mem bus
);
	initial
	begin
		if (DEPTH > (1 << AW) || DEPTH < 1)
			$error("burst buffer depth does not fit its address width");
	end
	logic [31:0] store [DEPTH]; // word storage
	// write port
	always_ff @(posedge mclk)
	begin
		if (bus.wrEn)
			store[bus.wrAddr] <= bus.wrData;
	end
	// read port, one cycle latency
	always_ff @(posedge mclk)
	begin
		bus.rdData <= store[bus.rdAddr];
	end
endmodule : jbab_burst_buf
`default_nettype wire

// File: design/jbab_pin_sync.sv
// two-stage synchroniser for the debug link pins
`timescale 1ns/1ps
`default_nettype none
module jbab_pin_sync #(parameter int WIDTH = 3) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);
	initial
	begin
		if (WIDTH < 1)
			$error("synchroniser needs at least one bit");
	end
	logic [WIDTH-1:0] stage1; // first stage, read only by the second
	// two flip-flops per pin
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			pinSync <= '0;
		end
		else
		begin
			stage1 <= pinIn;
			pinSync <= stage1;
		end
	end
endmodule : jbab_pin_sync
`default_nettype wire

// File: testbench/jbab_bus_mem.sv
// system bus memory model that answers the access block's bus master
`timescale 1ns/1ps
`default_nettype none
module jbab_bus_mem (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic busReq,
	input wire logic busWrite,
	input wire logic [31:0] busAddr,
	input wire logic [31:0] busWdata,
	input wire logic [1:0] busSize,
	output logic busAck,
	output logic busErr,
	output logic [31:0] busRdata
);
	logic [31:0] mem [0:31]; // word store, byte address bits 6:2
	logic [2:0] cnt; // wait states spent on the current beat
	logic slow; // alternates prompt and slow answers
	logic [31:0] word; // addressed word cut to the beat size
	// narrow reads return the low lanes only
	always_comb
	begin
		case (busSize)
			2'h0: word = mem[busAddr[6:2]] & 32'h000000FF;
			2'h1: word = mem[busAddr[6:2]] & 32'h0000FFFF;
			default: word = mem[busAddr[6:2]];
		endcase
	end
	// one-cycle ack after 0 or 4 wait states; top half of space fails
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 3'h0;
			slow <= 1'b0;
			busAck <= 1'b0;
			busErr <= 1'b0;
			busRdata <= 32'h00000000;
		end
		else
		begin
			busAck <= 1'b0;
			busErr <= 1'b0;
			// read data is scrambled outside the ack cycle
			busRdata <= ~busRdata;
			if (busReq && !busAck)
			begin
				if (cnt == (slow ? 3'h4 : 3'h0))
				begin
					cnt <= 3'h0;
					slow <= ~slow;
					busAck <= 1'b1;
					busErr <= busAddr[31];
					if (busWrite)
						mem[busAddr[6:2]] <= busWdata;
					else
						busRdata <= word;
				end
				else
					cnt <= cnt + 3'h1;
			end
		end
	end
endmodule : jbab_bus_mem
`default_nettype wire

// File: testbench/test_jtag_bus_access_block.sv
// self-checking bench: debug tool on the link pins, memory on the bus
`timescale 1ns/1ps
`default_nettype none
`include "jbab_regs.svh"
`define CHK(nm, ex, gt) \
	begin \
		checks++; \
		if ((gt) !== (ex)) \
		begin \
			badCount++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
		end \
	end
module test_jtag_bus_access_block;
	logic mclk, rst_n, tck, tms, tdi; // clock, reset and link pins
	logic tdo, tdoOe, xferDone, busReq, busWrite, busAck, busErr;
	logic [31:0] busAddr, busWdata, busRdata; // bus words
	logic [1:0] busSize, busPrio; // bus qualifiers
	logic [31:0] seed, addr, w, cw, rd; // stimulus and read-back
	logic [31:0] bw [0:7]; // burst words as written
	logic oeSeen; // output enable seen in a shift cycle
	logic errSeen = 1'b0; // a failing beat was answered
	logic [1:0] prioSeen = 2'h0; // arbitration level of that beat
	int checks = 0; // comparisons made
	int badCount = 0; // mismatches found
	int cycles = 0; // run length guard
	jbab_access jbab_access_i (.mclk(mclk), .rst_n(rst_n), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .xferDone(xferDone),
		.busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
		.busWdata(busWdata), .busSize(busSize), .busPrio(busPrio),
		.busAck(busAck), .busErr(busErr), .busRdata(busRdata));
	jbab_bus_mem jbab_bus_mem_i (.mclk(mclk), .rst_n(rst_n),
		.busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
		.busWdata(busWdata), .busSize(busSize), .busAck(busAck),
		.busErr(busErr), .busRdata(busRdata));
	// 50 MHz system clock
	always #10 mclk = ~mclk;
	// fixed-seed shift register for random data
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand
	// bus lane order of a register value, right-justified by size
	function automatic logic [31:0] byteView(input logic [31:0] d,
		input int sz);
		if (sz == 0)
			byteView = {24'h000000, d[7:0]};
		else if (sz == 1)
			byteView = {16'h0000, d[7:0], d[15:8]};
		else
			byteView = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction : byteView
	// one 160 ns link clock period; tdo taken late in the low phase
	task automatic tick(input logic m, input logic d, output logic q);
		@(negedge mclk);
		tms = m;
		tdi = d;
		tck = 1'b0;
		repeat (4) @(negedge mclk);
		q = tdo;
		oeSeen = tdoOe;
		tck = 1'b1;
		repeat (3) @(negedge mclk);
	endtask : tick
	// one pass from idle through a data or instruction path and back
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = 32'h00000000;
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
			if (i == 0)
				`CHK("tdoOe", 1'b1, oeSeen)
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : scan
	// register access: select pass, then data pass
	task automatic regAcc(input logic [6:0] idx, input logic wr,
		input logic [31:0] din, output logic [31:0] dout);
		logic [31:0] sel;
		scan(1'b0, 8, {24'h000000, idx, wr}, sel);
		scan(1'b0, 32, din, dout);
	endtask : regAcc
	// wait on the completion pin, bounded
	task automatic waitDone();
		int n;
		n = 0;
		// the launch clears a stale completion a few cycles after update
		repeat (2) @(negedge mclk);
		while (xferDone !== 1'b1 && n < 400)
		begin
			@(negedge mclk);
			n++;
		end
		`CHK("xferDone", 1'b1, xferDone)
	endtask : waitDone
	// counts, verdict and end of run
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : printVerdict
	// failing beats are noted with their arbitration level
	always @(posedge mclk)
	begin
		if (busAck && busErr)
		begin
			errSeen <= 1'b1;
			prioSeen <= busPrio;
		end
	end
	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			badCount++;
			$display("timeout reached");
			printVerdict();
		end
	end
	// main sequence
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		// link clock idles low like the synchroniser reset, no false edge
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		seed = 32'hB29D;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		tick(1'b0, 1'b0, oeSeen);
		// write attempted while access is still closed
		regAcc(`JBAB_IDX_ADDR, 1'b1, 32'h00000040, rd);
		scan(1'b1, 10, {22'h0, `JBAB_CMD_BUS_ACCESS}, rd);
		regAcc(`JBAB_IDX_ADDR, 1'b0, 32'h00000000, rd);
		`CHK("addr reset", `JBAB_ADDR_RST, rd)
		regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
		`CHK("ctrl reset", `JBAB_CTRL_RST, rd)
		$display("test closed port and reset values done");
		// single write then read back at each width
		for (int sz = 0; sz < 3; sz++)
		begin
			seed = nextRand(seed);
			addr = {27'h0, seed[4:2], 2'h0};
			cw = 32'h80000004 | (32'(sz) << 27) | (seed & 32'h001F0000);
			seed = nextRand(seed);
			w = seed;
			regAcc(`JBAB_IDX_ADDR, 1'b1, addr, rd);
			regAcc(`JBAB_IDX_CTRL, 1'b1, cw | 32'h40000000, rd);
			regAcc(`JBAB_IDX_DATA, 1'b1, w, rd);
			waitDone();
			`CHK("bus word", byteView(w, sz), jbab_bus_mem_i.mem[addr[6:2]])
			regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
			`CHK("ctrl", cw & 32'h7FE0FFFC | 32'h40000000, rd & 32'h7FFFFFFC)
			`CHK("write status", 2'h0, rd[1:0])
			regAcc(`JBAB_IDX_CTRL, 1'b1, cw, rd);
			waitDone();
			regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
			`CHK("read status", 2'h1, rd[1:0])
			regAcc(`JBAB_IDX_DATA, 1'b0, 32'h00000000, rd);
			`CHK("read data", byteView(byteView(w, sz), sz), rd)
		end
		$display("test single accesses done");
		// burst write from an unaligned start address
		cw = 32'h80000000 | (32'(`JBAB_WIDTH_64) << 27) | 32'h00200010;
		regAcc(`JBAB_IDX_ADDR, 1'b1, 32'h00000025, rd);
		regAcc(`JBAB_IDX_CTRL, 1'b1, cw | 32'h40000000, rd);
		for (int i = 0; i < 8; i++)
		begin
			seed = nextRand(seed);
			bw[i] = seed;
			regAcc(`JBAB_IDX_DATA, 1'b1, seed, rd);
		end
		waitDone();
		for (int i = 0; i < 8; i++)
			`CHK("burst mem", byteView(bw[i], 2), jbab_bus_mem_i.mem[8 + i])
		regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
		`CHK("burst write status", 2'h0, rd[1:0])
		$display("test burst write done");
		// burst read of the same block
		regAcc(`JBAB_IDX_CTRL, 1'b1, cw, rd);
		waitDone();
		regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
		`CHK("burst read status", 2'h1, rd[1:0])
		for (int i = 0; i < 8; i++)
		begin
			regAcc(`JBAB_IDX_DATA, 1'b0, 32'h00000000, rd);
			`CHK("burst read", bw[i], rd)
		end
		$display("test burst read done");
		// failing single read at the highest arbitration level
		regAcc(`JBAB_IDX_ADDR, 1'b1, 32'h80000010, rd);
		regAcc(`JBAB_IDX_CTRL, 1'b1, 32'h90C00004, rd);
		for (int n = 0; n < 400 && !errSeen; n++)
			@(negedge mclk);
		`CHK("prio", 2'h3, prioSeen)
		regAcc(`JBAB_IDX_CTRL, 1'b0, 32'h00000000, rd);
		`CHK("fault status", 2'h2, rd[1:0])
		`CHK("no completion", 1'b0, xferDone)
		$display("test failing access done");
		printVerdict();
	end
endmodule : test_jtag_bus_access_block
`default_nettype wire
